// file: rivm_regs.svh
// Vector map constants for the reset and interrupt vector map
`ifndef RIVM_REGS_SVH
`define RIVM_REGS_SVH
`define RIVM_NUM_IRQ 56
`define RIVM_VEC_W 6
`define RIVM_ADDR_W 17
`define RIVM_RESET_ADDR 17'h0_0000
`define RIVM_TABLE_BASE 17'h0_0002
`define RIVM_SLOT_STEP 2
`define RIVM_BOOT_ADDR_DEF 17'h1_F000
`define RIVM_FUSE_PROGRAMMED 1'b0
`define RIVM_FIRST_IRQ_VEC 2
`define RIVM_PIN_CHANGE_REQUEST_2_IDX 10
`define RIVM_TIM4_LO 40
`define RIVM_USART3_HI 55
`endif

// file: rivm_pkg.sv
// Types for the reset and interrupt vector map
package rivm_pkg;
  typedef enum logic [1:0] {
    RIVM_ST_RESET = 2'b01,
    RIVM_ST_RUN = 2'b10
  } rivm_state_t;
  typedef struct packed {
    logic valid;
    logic is_reset;
    logic [5:0] vec_num;
    logic [16:0] addr;
  } rivm_vec_t;
  typedef struct packed {
    rivm_state_t st;
    logic fuse_taken;
    logic fuse;
    rivm_vec_t out;
  } rivm_regs_t;
endpackage

// file: rivm_top.sv
// Reset and interrupt vector address generator for the fetch unit
`timescale 1ns/100ps
`include "rivm_regs.svh"

// What this block does
// - Every reset cause goes to the reset vector, 0000 or boot start
// - External requests 0..7 at 0002..0010
// - Pin change 0..2 at 0012..0016
// - Watchdog 0018, timer 2 at 001A..001E
// - Timer 1 five vectors at 0020..0028
// - Timer 0 three vectors at 002A..002E
// - Serial peripheral done at 0030
// - Serial port 0 at 0032..0036
// - Comparator, converter, nonvolatile, timer 3 vectors
// - Serial port 1 at 0048..004C
// - Two-wire 004E, program store ready 0050
// - Timer 4 five vectors at 0052..005A
// - Timer 5 five vectors at 005C..0064
// - Serial port 2 at 0066..006A
// - Serial port 3 at 006C..0070
// - Programmed boot fuse sends reset to boot
// - Table select adds boot start to interrupt vectors
// - Reduced variant omits its limited vectors
// - Boot fuse is active low
module rivm_top #(
  parameter logic [16:0] BOOT_ADDR = `RIVM_BOOT_ADDR_DEF,
  parameter bit REDUCED_VARIANT = 1'b0
) (
  input wire logic sys_clk, // Core clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic boot_reset_select_fuse, // Fuse level, 0 = programmed
  input wire logic vector_table_select, // Core control bit, 1 = boot table
  input wire logic global_irq_enable, // Core interrupt enable
  input wire logic [55:0] irq_req, // Requests, bit i = vector i+2
  input wire logic [55:0] irq_enable, // Per-source enables
  input wire logic fetch_ack, // Fetch unit took the vector
  output logic vec_valid, // Vector address is valid
  output logic vec_is_reset, // Vector is the reset vector
  output logic [5:0] vec_num, // Vector number, 1..57
  output logic [16:0] vec_addr, // Word address in program memory
  output logic [55:0] irq_ack // One-cycle acknowledge to the source
);

  // ==========================================================
  // Source availability
  // ==========================================================
  logic [55:0] avail;
  logic [55:0] live;
  logic [55:0] first_one;
  logic [55:0] higher_seen;

  genvar gi;
  generate
    for (gi = 0; gi < `RIVM_NUM_IRQ; gi++) begin : g_src
      // Limited sources never reach the core in the reduced variant
      if (gi == `RIVM_PIN_CHANGE_REQUEST_2_IDX || (gi >= `RIVM_TIM4_LO && gi <= `RIVM_USART3_HI)) begin : g_lim
        assign avail[gi] = ~REDUCED_VARIANT;
      end else begin : g_full
        assign avail[gi] = 1'b1;
      end
      // A source being acknowledged drops out at once; its own request only falls a cycle later
      assign live[gi] = irq_req[gi] & irq_enable[gi] & avail[gi] & global_irq_enable & ~irq_ack[gi];
      // Priority chain: lowest index first
      if (gi == 0) begin : g_p0
        assign higher_seen[gi] = 1'b0;
      end else begin : g_pn
        assign higher_seen[gi] = higher_seen[gi-1] | live[gi-1];
      end
      assign first_one[gi] = live[gi] & ~higher_seen[gi];
    end
  endgenerate

  // ==========================================================
  // Winner encode and address
  // ==========================================================
  logic [5:0] win_idx;
  logic any_live;
  logic [16:0] irq_addr;
  logic [16:0] reset_addr;

  always_comb begin
    win_idx = 6'h00;
    for (int i = 0; i < `RIVM_NUM_IRQ; i++) begin
      if (first_one[i]) begin
        win_idx = 6'(i);
      end
    end
  end

  assign any_live = |live;

  // Slots are two words apart from the table base; every source index maps in order
  always_comb begin
    irq_addr = `RIVM_TABLE_BASE + 17'(win_idx) * 17'(`RIVM_SLOT_STEP);
    if (vector_table_select) begin
      irq_addr = irq_addr + BOOT_ADDR;
    end
  end

  // ==========================================================
  // State
  // ==========================================================
  rivm_pkg::rivm_regs_t r_q;
  rivm_pkg::rivm_regs_t r_d;

  always_comb begin
    reset_addr = (r_q.fuse == `RIVM_FUSE_PROGRAMMED) ? BOOT_ADDR : `RIVM_RESET_ADDR;
  end

  // Reset vector is issued first; fuse is sampled after release, never under reset
  always_comb begin
    r_d = r_q;
    r_d.fuse_taken = 1'b1;
    if (!r_q.fuse_taken) begin
      r_d.fuse = boot_reset_select_fuse;
    end
    unique case (r_q.st)
      rivm_pkg::RIVM_ST_RESET: begin
        // Held back one cycle so the address is built from the captured fuse
        r_d.out.valid = r_q.fuse_taken;
        r_d.out.is_reset = 1'b1;
        r_d.out.vec_num = 6'h01;
        r_d.out.addr = reset_addr;
        if (r_q.out.valid && fetch_ack) begin
          r_d.st = rivm_pkg::RIVM_ST_RUN;
          r_d.out.valid = 1'b0;
          r_d.out.is_reset = 1'b0;
        end
      end
      rivm_pkg::RIVM_ST_RUN: begin
        // A vector stays until taken, so a late lower request cannot swap it mid-fetch
        if (!r_q.out.valid || fetch_ack) begin
          r_d.out.valid = any_live;
          r_d.out.is_reset = 1'b0;
          r_d.out.vec_num = 6'(win_idx + 6'(`RIVM_FIRST_IRQ_VEC));
          r_d.out.addr = irq_addr;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r_q <= '{st: rivm_pkg::RIVM_ST_RESET, fuse_taken: 1'b0, fuse: 1'b1, out: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign vec_valid = r_q.out.valid & r_q.fuse_taken;
  assign vec_is_reset = r_q.out.is_reset;
  assign vec_num = r_q.out.vec_num;
  assign vec_addr = r_q.out.addr;

  generate
    for (gi = 0; gi < `RIVM_NUM_IRQ; gi++) begin : g_ack
      assign irq_ack[gi] = vec_valid & fetch_ack & ~r_q.out.is_reset &
                           (r_q.out.vec_num == 6'(gi + `RIVM_FIRST_IRQ_VEC));
    end
  endgenerate

  // ==========================================================
  // Checks
  // ==========================================================
  AST_RESET_ADDR: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_is_reset && r_q.fuse) |-> vec_addr == 17'h0_0000)
    else $error("reset vector not at zero");
  AST_BOOT_RESET: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_is_reset && !r_q.fuse) |-> vec_addr == BOOT_ADDR)
    else $error("programmed fuse did not redirect reset");
  AST_SLOT_MAP: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && !vec_is_reset && !vector_table_select && $stable(vector_table_select)) |->
      vec_addr == 17'((vec_num - 6'h01) * 2))
    else $error("vector address does not match number");
  AST_RELOCATE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_d.out.valid && !r_q.out.valid && r_q.st == rivm_pkg::RIVM_ST_RUN && vector_table_select) |=>
      vec_addr == 17'(BOOT_ADDR + 17'((vec_num - 6'h01) * 2)))
    else $error("relocated vector wrong");
  AST_LIMITED: assert property (@(posedge sys_clk) disable iff (!nrst)
    (REDUCED_VARIANT && vec_valid) |-> !(vec_num == 6'd12 || (vec_num >= 6'd42 && vec_num <= 6'd57)))
    else $error("limited vector issued");
  AST_PRIO: assert property (@(posedge sys_clk) disable iff (!nrst)
    (any_live && !r_q.out.valid && r_q.st == rivm_pkg::RIVM_ST_RUN) |=>
      (vec_valid && (($past(live) & (~$past(live) + 56'h1)) == (56'h1 << (vec_num - 6'd2)))))
    else $error("priority winner not issued");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && !fetch_ack) |=> vec_valid && $stable(vec_addr) && $stable(vec_num))
    else $error("vector changed before it was taken");
  AST_TIMER5_END: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd51 && !vector_table_select) |-> vec_addr == 17'h0_0064)
    else $error("timer 5 overflow slot wrong");
  AST_LAST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd57 && !vector_table_select) |-> vec_addr == 17'h0_0070)
    else $error("last slot wrong");

  // ==========================================================
  // Slot checks, one or two per group of sources but none for converter and nonvolatile
  // ==========================================================
  // Table select is sampled at load, so these expect it low while a vector stands
  AST_EXT_LAST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd9 && !vector_table_select) |-> vec_addr == 17'h0_0010)
    else $error("external request 7 slot wrong");

  AST_PIN_CHANGE_FIRST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd10 && !vector_table_select) |-> vec_addr == 17'h0_0012)
    else $error("pin change 0 slot wrong");

  AST_PIN_CHANGE_LAST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd12 && !vector_table_select) |-> vec_addr == 17'h0_0016)
    else $error("pin change 2 slot wrong");

  AST_WATCHDOG: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd13 && !vector_table_select) |-> vec_addr == 17'h0_0018)
    else $error("watchdog slot wrong");

  AST_TIMER2_END: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd16 && !vector_table_select) |-> vec_addr == 17'h0_001E)
    else $error("timer 2 overflow slot wrong");

  AST_TIMER1_FIRST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd17 && !vector_table_select) |-> vec_addr == 17'h0_0020)
    else $error("timer 1 capture slot wrong");

  AST_TIMER1_END: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd21 && !vector_table_select) |-> vec_addr == 17'h0_0028)
    else $error("timer 1 overflow slot wrong");

  AST_TIMER0_FIRST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd22 && !vector_table_select) |-> vec_addr == 17'h0_002A)
    else $error("timer 0 match a slot wrong");

  AST_SERIAL_DONE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd25 && !vector_table_select) |-> vec_addr == 17'h0_0030)
    else $error("serial peripheral slot wrong");

  AST_PORT0_FIRST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd26 && !vector_table_select) |-> vec_addr == 17'h0_0032)
    else $error("serial port 0 slot wrong");

  AST_COMPARATOR: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd29 && !vector_table_select) |-> vec_addr == 17'h0_0038)
    else $error("comparator slot wrong");

  AST_TIMER3_END: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd36 && !vector_table_select) |-> vec_addr == 17'h0_0046)
    else $error("timer 3 overflow slot wrong");

  AST_PORT1_FIRST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd37 && !vector_table_select) |-> vec_addr == 17'h0_0048)
    else $error("serial port 1 slot wrong");

  AST_TWO_WIRE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd40 && !vector_table_select) |-> vec_addr == 17'h0_004E)
    else $error("two-wire slot wrong");

  AST_STORE_READY: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd41 && !vector_table_select) |-> vec_addr == 17'h0_0050)
    else $error("program store ready slot wrong");

  AST_TIMER4_FIRST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd42 && !vector_table_select) |-> vec_addr == 17'h0_0052)
    else $error("timer 4 capture slot wrong");

  AST_TIMER5_FIRST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd47 && !vector_table_select) |-> vec_addr == 17'h0_005C)
    else $error("timer 5 capture slot wrong");

  AST_PORT2_FIRST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd52 && !vector_table_select) |-> vec_addr == 17'h0_0066)
    else $error("serial port 2 slot wrong");

  AST_PORT3_FIRST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && vec_num == 6'd55 && !vector_table_select) |-> vec_addr == 17'h0_006C)
    else $error("serial port 3 slot wrong");

  // ==========================================================
  // Handshake and refusal checks
  // ==========================================================
  AST_RESET_FIRST: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && r_q.st == rivm_pkg::RIVM_ST_RESET) |-> (vec_is_reset && vec_num == 6'h01))
    else $error("first vector after reset is not the reset vector");

  AST_FUSE_HELD: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.fuse_taken && $past(r_q.fuse_taken)) |-> $stable(r_q.fuse))
    else $error("boot fuse level changed after capture");

  AST_ACK_MATCH: assert property (@(posedge sys_clk) disable iff (!nrst)
    (vec_valid && fetch_ack && !vec_is_reset) |-> irq_ack == (56'h1 << (vec_num - 6'd2)))
    else $error("acknowledge does not match the vector taken");

  AST_ACK_QUIET: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(vec_valid && fetch_ack && !vec_is_reset) |-> irq_ack == 56'h0)
    else $error("acknowledge without a take");

  AST_GLOBAL_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.st == rivm_pkg::RIVM_ST_RUN && !r_q.out.valid && !global_irq_enable) |=>
      !vec_valid)
    else $error("vector issued while interrupts disabled");

  AST_ENABLED: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.st == rivm_pkg::RIVM_ST_RUN && !r_q.out.valid) |=>
      (!vec_valid || ($past(irq_req & irq_enable) & (56'h1 << (vec_num - 6'd2))) != 56'h0))
    else $error("vector issued for a source not requested and enabled");

endmodule

// file: rivm_fetch_model.sv
// Fetch unit model that takes each presented vector after a stall
`timescale 1ns/100ps
module rivm_fetch_model (
  input wire logic sys_clk, // Core clock
  input wire logic nrst, // Reset, active low
  input wire logic vec_valid, // Vector presented
  input wire logic [3:0] stall, // Wait cycles before a take
  output logic fetch_ack // Take strobe
);
  logic [3:0] wait_q;
  // One-cycle take, so a vector replacing the old one is never taken blind
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 4'h0;
      fetch_ack <= 1'b0;
    end else begin
      fetch_ack <= vec_valid && !fetch_ack && wait_q >= stall;
      wait_q <= (vec_valid && !fetch_ack && wait_q < stall) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule

// file: testbench.sv
// Self-checking bench for the reset and interrupt vector map
`timescale 1ns/100ps
module testbench;
  localparam logic [16:0] BOOT = 17'h1_F000;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic fuse = 1'b1;
  logic vts = 1'b0;
  logic gie = 1'b0;
  logic [55:0] req = '0;
  logic [55:0] ena = '0;
  logic [3:0] stall = 4'h0;
  logic ack, vld, is_rst;
  logic [5:0] num;
  logic [16:0] addr;
  logic [55:0] iack;
  logic lim_vld, lim_ack;
  logic [55:0] lim_iack;
  logic [55:0] lim_seen = '0;
  rivm_pkg::rivm_vec_t tq[$];
  logic [55:0] aq[$];
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int i, a, b;
  logic sel;
  rivm_top #(.BOOT_ADDR(BOOT), .REDUCED_VARIANT(1'b0)) DUT (.sys_clk(sys_clk), .nrst(nrst),
    .boot_reset_select_fuse(fuse), .vector_table_select(vts), .global_irq_enable(gie), .irq_req(req),
    .irq_enable(ena), .fetch_ack(ack), .vec_valid(vld), .vec_is_reset(is_rst), .vec_num(num),
    .vec_addr(addr), .irq_ack(iack));
  rivm_fetch_model PARTNER (.sys_clk(sys_clk), .nrst(nrst), .vec_valid(vld), .stall(stall), .fetch_ack(ack));
  // Reduced variant beside the full one, fed the same requests
  rivm_top #(.BOOT_ADDR(BOOT), .REDUCED_VARIANT(1'b1)) DUT_LIM (.sys_clk(sys_clk), .nrst(nrst),
    .boot_reset_select_fuse(fuse), .vector_table_select(vts), .global_irq_enable(gie), .irq_req(req),
    .irq_enable(ena), .fetch_ack(lim_ack), .vec_valid(lim_vld), .vec_is_reset(), .vec_num(),
    .vec_addr(), .irq_ack(lim_iack));
  rivm_fetch_model PARTNER_LIM (.sys_clk(sys_clk), .nrst(nrst), .vec_valid(lim_vld), .stall(stall),
    .fetch_ack(lim_ack));
  initial forever #4 sys_clk = ~sys_clk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [55:0] exp, input logic [55:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Sources drop a request once the full variant acknowledges it, as a real peripheral does
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    lim_seen <= lim_seen | lim_iack;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
    if (vld === 1'b1 && ack === 1'b1) begin
      tq.push_back(rivm_pkg::rivm_vec_t'{1'b1, is_rst, num, addr});
      aq.push_back(iack);
      req <= req & ~iack;
    end
  end
  // Sources left out of the reduced variant: vector 12 and vectors 42 and up
  function automatic logic [55:0] lim_mask();
    lim_mask = '0;
    for (int j = 0; j < 56; j++) begin
      if (j + 2 == 12 || j + 2 >= 42) begin
        lim_mask[j] = 1'b1;
      end
    end
  endfunction
  function automatic logic [16:0] vaddr(input int idx, input logic s);
    vaddr = 17'(2 * (idx + 1)) + (s ? BOOT : 17'h0_0000);
  endfunction
  task automatic expect_vec(input int n, input logic r, input logic [16:0] ea, input logic [55:0] ek);
    int k;
    rivm_pkg::rivm_vec_t v;
    k = 0;
    while (tq.size() == 0 && k < 40) begin
      @(posedge sys_clk);
      k++;
    end
    if (tq.size() == 0) begin
      check("vector taken", 56'h1, 56'h0);
    end else begin
      v = tq.pop_front();
      check("vec_num", 56'(n), 56'(v.vec_num));
      check("vec_is_reset", 56'(r), 56'(v.is_reset));
      check("vec_addr", 56'(ea), 56'(v.addr));
      check("irq_ack", ek, aq.pop_front());
    end
  endtask
  task automatic do_reset(input logic f);
    nrst <= 1'b0;
    fuse <= f;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask
  initial begin
    void'($urandom(9382));
    do_reset(1'b1);
    expect_vec(1, 1'b1, 17'h0_0000, '0);
    do_reset(1'b0);
    expect_vec(1, 1'b1, BOOT, '0);
    @(posedge sys_clk);
    gie <= 1'b1;
    ena <= '1;
    for (i = 0; i < 56; i++) begin
      @(posedge sys_clk);
      sel = 1'($urandom_range(0, 1));
      vts <= sel;
      stall <= 4'($urandom_range(0, 3));
      req[i] <= 1'b1;
      expect_vec(i + 2, 1'b0, vaddr(i, sel), 56'h1 << i);
    end
    // Masked and globally disabled requests must stay silent
    @(posedge sys_clk);
    vts <= 1'b0;
    ena[7] <= 1'b0;
    req[7] <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check("masked vec_valid", 56'h0, 56'(vld));
    gie <= 1'b0;
    ena[7] <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check("disabled vec_valid", 56'h0, 56'(vld));
    gie <= 1'b1;
    expect_vec(9, 1'b0, 17'h0_0010, 56'h1 << 7);
    for (i = 0; i < 20; i++) begin
      a = (i == 0) ? 0 : $urandom_range(0, 54);
      b = (i == 0) ? 55 : $urandom_range(a + 1, 55);
      @(posedge sys_clk);
      stall <= 4'($urandom_range(0, 2));
      req[a] <= 1'b1;
      req[b] <= 1'b1;
      expect_vec(a + 2, 1'b0, vaddr(a, 1'b0), 56'h1 << a);
      expect_vec(b + 2, 1'b0, vaddr(b, 1'b0), 56'h1 << b);
    end
    check("reduced variant acks", ~lim_mask(), lim_seen);
    summarize();
  end
endmodule
